// ===== rcwd_consts.vh
// constants for the reset control and watchdog block
//
// Contract
// - request pin low beyond 1032 half-periods is a long hardware reset; code reports it as power-on when mode-select is low
// - low pulse over 4 and up to 1032 half-periods is short hardware reset
// - five reset sources: power-on, long, short, watchdog, software
// - request low with mode-select low enters asynchronous reset at once
// - async reset: indicator low, tri-state, config port high, sequence; code skips ST_SEQ, ST_ASYNC goes straight to ST_LATCH
// - asynchronous request is detected without a running clock
// - request high: latch config, strobes inactive, start at address zero
// - config latched 3 CPU cycles after rise with prescaler bypass, else 4
// - request low with mode-select high starts sync reset, held 4 OSC_HALF_PERIOD
// - during sync reset pins tri-state and indicator driven low
// - sync request detected: 12 half-periods cancel holds, abort bus
// - pin pulldown only if drive-enable set; bit cleared after reset
// - watchdog on after reset; disable only before end of init
// - watchdog overflow makes internal reset and pulls indicator low
// - 16-bit watchdog at clock over 2 or over 128 by prescale select
// - each service loads counter high byte from reload value
// - timeout spans 20.48us to 336ms at 25MHz CPU clock
// - internal sequence lasts 1024 half-periods, extended while pin low
// - indicator stays low after reset until end of init executes
`ifndef RCWD_CONSTS_VH
`define RCWD_CONSTS_VH
`define RCWD_CLK_PERIOD_NS 4
`define RCWD_CPU_CYC_PER_HALF 2
`define RCWD_TCL_LONG 1032
`define RCWD_TCL_SHORT 4
`define RCWD_TCL_ABORT 12
`define RCWD_TCL_SEQ 1024
`define RCWD_LATCH_CYC_BYPASS 3
`define RCWD_LATCH_CYC_NORMAL 4
`define RCWD_WDT_DIV_FAST 2
`define RCWD_WDT_DIV_SLOW 128
`define RCWD_RESTART_ADDR 24'h000000
`define RCWD_RESTART_SEG 8'h00
`define RCWD_SRC_NONE 3'h0
`define RCWD_SRC_PON 3'h1
`define RCWD_SRC_LHW 3'h2
`define RCWD_SRC_SHW 3'h3
`define RCWD_SRC_WDT 3'h4
`define RCWD_SRC_SW 3'h5
`define RCWD_CFG_KEEP_HI 12
`define RCWD_CFG_KEEP_LO 8
`define RCWD_CFG_CLR_HI 7
`define RCWD_CFG_CLR_LO 2
`endif

// ===== rcwd_reset_control.v
// reset sequencer with watchdog, source classification and start-up latch
`timescale 1ns/1ps
`include "rcwd_consts.vh"
module rcwd_reset_control #(
    parameter TCL_PER_CYC = 2,
    parameter SEQ_CYC = `RCWD_TCL_SEQ / `RCWD_CPU_CYC_PER_HALF,
    parameter LONG_CYC = `RCWD_TCL_LONG / `RCWD_CPU_CYC_PER_HALF,
    parameter SHORT_CYC = `RCWD_TCL_SHORT / `RCWD_CPU_CYC_PER_HALF,
    parameter ABORT_CYC = `RCWD_TCL_ABORT / `RCWD_CPU_CYC_PER_HALF,
    parameter CFG_W = 16
) (
    input wire clk,
    input wire reset,
    input wire clk_en,
    input wire reset_request_pin_n,
    input wire reset_mode_select_pin,
    input wire [CFG_W-1:0] config_port,
    input wire prescaler_bypass,
    input wire software_reset_instr,
    input wire end_of_init_instr,
    input wire watchdog_service,
    input wire watchdog_disable,
    input wire watchdog_control_write,
    input wire [7:0] watchdog_reload_value,
    input wire watchdog_prescale_select,
    input wire reset_pin_drive_enable_set,
    output reg reset_indicator_out_n,
    output reg reset_pin_pulldown,
    output reg io_tristate,
    output reg config_port_pullup,
    output reg bus_abort,
    output reg strobes_inactive,
    output reg cpu_run,
    output reg [23:0] restart_addr,
    output reg [7:0] restart_seg,
    output reg [CFG_W-1:0] system_config_reg,
    output reg [2:0] reset_source,
    output reg watchdog_enabled,
    output reg [15:0] watchdog_count,
    output reg reset_pin_drive_enable
);

////////////////////////////////////////////////////////////////////////////
localparam [2:0] ST_RUN = 3'h0;
localparam [2:0] ST_ABORT = 3'h1;
localparam [2:0] ST_SEQ = 3'h2;
localparam [2:0] ST_WAIT_HI = 3'h3;
localparam [2:0] ST_LATCH = 3'h4;
localparam [2:0] ST_ASYNC = 3'h5;
// counts are cut to the counter widths on purpose; 11 bits hold 2047 cycles
localparam integer SEQ_I = SEQ_CYC;
localparam integer LONG_I = LONG_CYC;
localparam integer SHORT_I = SHORT_CYC;
localparam integer ABORT_I = ABORT_CYC;
localparam integer LATCH_BYP_I = `RCWD_LATCH_CYC_BYPASS;
localparam integer LATCH_NRM_I = `RCWD_LATCH_CYC_NORMAL;
// prescaler terminal values; with the reload range they set the timeout span
localparam integer DIV_FAST_I = `RCWD_WDT_DIV_FAST - 1;
localparam integer DIV_SLOW_I = `RCWD_WDT_DIV_SLOW - 1;
localparam [10:0] SEQ_N = SEQ_I[10:0];
localparam [10:0] LONG_N = LONG_I[10:0];
localparam [10:0] SHORT_N = SHORT_I[10:0];
localparam [10:0] ABORT_N = ABORT_I[10:0];
localparam [2:0] LATCH_BYP = LATCH_BYP_I[2:0];
localparam [2:0] LATCH_NRM = LATCH_NRM_I[2:0];
localparam [6:0] DIV_FAST = DIV_FAST_I[6:0];
localparam [6:0] DIV_SLOW = DIV_SLOW_I[6:0];

// asynchronous entry: pin low with mode-select low forces reset without clock
wire async_rst;
assign async_rst = reset | (~reset_request_pin_n & ~reset_mode_select_pin);

////////////////////////////////////////////////////////////////////////////
// pin synchronisers
reg rq_m_q, rq_s_q, ms_m_q, ms_s_q;
always @(posedge clk or posedge reset) begin
    if (reset) begin
        rq_m_q <= 1'b1;
        rq_s_q <= 1'b1;
        ms_m_q <= 1'b0;
        ms_s_q <= 1'b0;
    end else if (clk_en) begin
        rq_m_q <= reset_request_pin_n;
        rq_s_q <= rq_m_q;
        ms_m_q <= reset_mode_select_pin;
        ms_s_q <= ms_m_q;
    end
end
wire rq_low;
assign rq_low = ~rq_s_q;

////////////////////////////////////////////////////////////////////////////
reg [2:0] state_q;
reg [10:0] cnt_q;
reg [10:0] low_q;
reg [2:0] lat_q;
reg was_async_q;
reg [6:0] pre_q;
reg end_of_init_instr_q;
reg wdt_ovf;

always @* begin
    wdt_ovf = 1'b0;
    if (state_q == ST_RUN && watchdog_enabled && watchdog_count == 16'hFFFF)
        wdt_ovf = (pre_q == (watchdog_prescale_select ? DIV_SLOW : DIV_FAST));
end

function [2:0] classify;
    input [10:0] low_len;
    begin
        if (low_len > LONG_N)
            classify = `RCWD_SRC_LHW;
        else
            classify = `RCWD_SRC_SHW;
    end
endfunction

always @(posedge clk or posedge async_rst) begin
    if (async_rst) begin
        state_q <= ST_ASYNC;
        cnt_q <= 11'h000;
        low_q <= 11'h000;
        lat_q <= 3'h0;
        was_async_q <= 1'b1;
        reset_indicator_out_n <= 1'b0;
        reset_pin_pulldown <= 1'b0;
        io_tristate <= 1'b1;
        config_port_pullup <= 1'b1;
        bus_abort <= 1'b1;
        strobes_inactive <= 1'b1;
        cpu_run <= 1'b0;
        restart_addr <= `RCWD_RESTART_ADDR;
        restart_seg <= `RCWD_RESTART_SEG;
        system_config_reg <= {CFG_W{1'b0}};
        reset_source <= `RCWD_SRC_PON;
        watchdog_enabled <= 1'b1;
        watchdog_count <= 16'h0000;
        reset_pin_drive_enable <= 1'b0;
        pre_q <= 7'h00;
        end_of_init_instr_q <= 1'b0;
    end else if (clk_en) begin
        bus_abort <= 1'b0;
        case (state_q)
        ST_ASYNC: begin
            if (~rq_low) begin
                if (reset_source != `RCWD_SRC_PON)
                    reset_source <= `RCWD_SRC_LHW;
                state_q <= ST_LATCH;
                lat_q <= 3'h1;
            end
        end
        ST_RUN: begin
            if (rq_low)
                low_q <= (low_q == 11'h7FF) ? low_q : low_q + 11'h001;
            else
                low_q <= 11'h000;
            // watchdog prescaler and counter
            if (watchdog_enabled) begin
                if (pre_q == (watchdog_prescale_select ? DIV_SLOW : DIV_FAST))
                begin
                    pre_q <= 7'h00;
                    watchdog_count <= watchdog_count + 16'h0001;
                end else begin
                    pre_q <= pre_q + 7'h01;
                end
            end
            // strobes are one clock wide and only honoured while running
            if (watchdog_service)
                watchdog_count <= {watchdog_reload_value, 8'h00};
            if (watchdog_disable && !end_of_init_instr_q)
                watchdog_enabled <= 1'b0;
            if (end_of_init_instr) begin
                end_of_init_instr_q <= 1'b1;
                reset_indicator_out_n <= 1'b1;
            end
            if (reset_pin_drive_enable_set)
                reset_pin_drive_enable <= 1'b1;
            // pulse must span the short minimum before sync reset starts
            if (rq_low && ms_s_q && low_q + 11'h001 >= SHORT_N) begin
                reset_source <= `RCWD_SRC_SHW;
                state_q <= ST_ABORT;
            end else if (wdt_ovf) begin
                reset_source <= `RCWD_SRC_WDT;
                state_q <= ST_ABORT;
            end else if (software_reset_instr) begin
                reset_source <= `RCWD_SRC_SW;
                state_q <= ST_ABORT;
            end
            if ((rq_low && ms_s_q && low_q + 11'h001 >= SHORT_N) || wdt_ovf ||
                software_reset_instr) begin
                reset_indicator_out_n <= 1'b0;
                io_tristate <= 1'b1;
                bus_abort <= 1'b1;
                cpu_run <= 1'b0;
                cnt_q <= 11'h000;
                was_async_q <= 1'b0;
            end
        end
        ST_ABORT: begin
            if (rq_low)
                low_q <= (low_q == 11'h7FF) ? low_q : low_q + 11'h001;
            // abort flag counts the entry cycle, so it drops on the exit edge
            if (cnt_q + 11'h001 >= ABORT_N) begin
                cnt_q <= 11'h000;
                state_q <= ST_SEQ;
                reset_pin_pulldown <= reset_pin_drive_enable;
            end else begin
                bus_abort <= 1'b1;
                cnt_q <= cnt_q + 11'h001;
            end
        end
        ST_SEQ: begin
            if (rq_low)
                low_q <= (low_q == 11'h7FF) ? low_q : low_q + 11'h001;
            if (cnt_q + 11'h001 >= SEQ_N) begin
                reset_pin_pulldown <= 1'b0;
                reset_pin_drive_enable <= 1'b0;
                state_q <= ST_WAIT_HI;
            end else begin
                cnt_q <= cnt_q + 11'h001;
            end
        end
        ST_WAIT_HI: begin
            if (rq_low) begin
                low_q <= (low_q == 11'h7FF) ? low_q : low_q + 11'h001;
            end else begin
                if (reset_source == `RCWD_SRC_SHW)
                    reset_source <= classify(low_q);
                state_q <= ST_LATCH;
                lat_q <= 3'h1;
            end
        end
        ST_LATCH: begin
            // a latch delay counts from entry here, once the synchronised request pin reads high
            if (lat_q >= (prescaler_bypass ? LATCH_BYP : LATCH_NRM)) begin
                if (reset_source == `RCWD_SRC_SW ||
                    reset_source == `RCWD_SRC_WDT) begin
                    system_config_reg[`RCWD_CFG_KEEP_HI:`RCWD_CFG_KEEP_LO] <=
                        config_port[`RCWD_CFG_KEEP_HI:`RCWD_CFG_KEEP_LO];
                    system_config_reg[`RCWD_CFG_CLR_HI:`RCWD_CFG_CLR_LO] <=
                        6'h00;
                end else begin
                    system_config_reg <= config_port;
                end
                strobes_inactive <= 1'b1;
                restart_addr <= `RCWD_RESTART_ADDR;
                restart_seg <= `RCWD_RESTART_SEG;
                io_tristate <= 1'b0;
                config_port_pullup <= 1'b0;
                cpu_run <= 1'b1;
                watchdog_enabled <= 1'b1;
                watchdog_count <= 16'h0000;
                pre_q <= 7'h00;
                end_of_init_instr_q <= 1'b0;
                low_q <= 11'h000;
                reset_pin_drive_enable <= 1'b0;
                state_q <= ST_RUN;
            end else begin
                lat_q <= lat_q + 3'h1;
            end
        end
        default: state_q <= ST_ASYNC;
        endcase
    end
end

endmodule

// ===== rcwd_ext_reset.sv
// model of the board reset circuit driving request and mode-select pins
`timescale 1ns/1ps
module rcwd_ext_reset (
    input wire clk,
    input wire por,
    input wire req,
    input wire warm,
    output reg rst_n,
    output reg mode
);
    // a request is stretched so the pin never stays low under 2 cycles
    reg [1:0] cnt_q = 2'h0;
    initial rst_n = 1'b0;
    initial mode = 1'b0;
    always @(posedge clk) begin
        mode <= warm & ~por;
        if (por | req) begin
            rst_n <= 1'b0;
            cnt_q <= 2'h0;
        end else if (cnt_q != 2'h2) begin
            cnt_q <= cnt_q + 2'h1;
        end else begin
            rst_n <= 1'b1;
        end
    end
endmodule

// ===== rcwd_reset_control_properties.sv
// concurrent checks on the reset control and watchdog ports
`timescale 1ns/1ps
module rcwd_reset_control_properties (
    input wire clk,
    input wire reset,
    input wire reset_request_pin_n,
    input wire reset_mode_select_pin,
    input wire watchdog_service,
    input wire end_of_init_instr,
    input wire [7:0] watchdog_reload_value,
    input wire reset_indicator_out_n,
    input wire io_tristate,
    input wire config_port_pullup,
    input wire bus_abort,
    input wire cpu_run,
    input wire watchdog_enabled,
    input wire [15:0] watchdog_count,
    input wire reset_pin_pulldown
);
    default clocking dcb @(posedge clk); endclocking
    default disable iff (reset);
    ////////////////////////////////////////////////////////////////////////
    property p_async; !reset_request_pin_n && !reset_mode_select_pin |->
        !reset_indicator_out_n && io_tristate && config_port_pullup; endproperty
    a_async: assert property (p_async) else $error("async entry");
    property p_sync; $fell(reset_request_pin_n) && reset_mode_select_pin &&
        cpu_run |-> ##[2:6] (!reset_indicator_out_n && io_tristate); endproperty
    a_sync: assert property (p_sync) else $error("sync entry");
    // mode high excludes the async path, where abort follows the chip reset
    property p_abort; $rose(bus_abort) && reset_mode_select_pin |->
        bus_abort [*6] ##1 !bus_abort; endproperty
    a_abort: assert property (p_abort) else $error("abort length");
    property p_hold; !reset_request_pin_n [*8] |-> !cpu_run; endproperty
    a_hold: assert property (p_hold) else $error("ran with pin low");
    property p_svc; cpu_run && watchdog_service && watchdog_enabled |=>
        watchdog_count == {$past(watchdog_reload_value), 8'h00}; endproperty
    a_svc: assert property (p_svc) else $error("reload");
    property p_end_of_init_instr; $rose(reset_indicator_out_n) |->
        $past(end_of_init_instr); endproperty
    a_end_of_init_instr: assert property (p_end_of_init_instr) else $error("early release");
    property p_wdt_on; $rose(cpu_run) |-> watchdog_enabled; endproperty
    a_wdt_on: assert property (p_wdt_on) else $error("wdt off");
    property p_late; reset_indicator_out_n && watchdog_enabled |=>
        watchdog_enabled; endproperty
    a_late: assert property (p_late) else $error("late disable");
    property p_pd; reset_pin_pulldown |-> !cpu_run; endproperty
    a_pd: assert property (p_pd) else $error("pulldown running");
    cover property ($rose(cpu_run));
    cover property ($rose(bus_abort));
    cover property (cpu_run && watchdog_service);
endmodule
bind rcwd_reset_control rcwd_reset_control_properties u_props (.clk, .reset,
    .reset_request_pin_n, .reset_mode_select_pin, .watchdog_service,
    .end_of_init_instr, .watchdog_reload_value, .reset_indicator_out_n,
    .io_tristate, .config_port_pullup, .bus_abort, .cpu_run,
    .watchdog_enabled, .watchdog_count, .reset_pin_pulldown);

// ===== rcwd_reset_control_tb.sv
// self-checking bench for the reset control and watchdog block
`timescale 1ns/1ps
module rcwd_reset_control_tb;
    localparam SEQ = 16;
    reg clk = 1'b0, reset = 1'b1, clk_en = 1'b1, por = 1'b1, req = 1'b0;
    reg warm = 1'b0, bypass = 1'b0, pd_seen = 1'b0, pd_clr = 1'b0;
    reg [5:0] stb = 6'h00;
    reg [7:0] rel = 8'h00;
    reg [15:0] cfg = 16'hA5C3;
    wire ext_n, mode, ind_n, pd, tri_o, pu, abort, strb, run, wen, pden;
    wire pin_n = ext_n & ~pd;
    wire [23:0] addr;
    wire [7:0] seg;
    wire [15:0] syscfg, wcnt;
    wire [2:0] src;
    int err_count = 0, n_checks = 0, n, nb [2];
    rcwd_ext_reset u_rcwd_ext_reset (.clk(clk), .por(por), .req(req),
        .warm(warm), .rst_n(ext_n), .mode(mode));
    rcwd_reset_control #(.SEQ_CYC(SEQ)) u_rcwd_reset_control (.clk(clk),
        .reset(reset), .clk_en(clk_en), .reset_request_pin_n(pin_n),
        .reset_mode_select_pin(mode), .config_port(cfg),
        .prescaler_bypass(bypass), .software_reset_instr(stb[0]),
        .end_of_init_instr(stb[1]), .watchdog_service(stb[2]),
        .watchdog_disable(stb[3]), .watchdog_control_write(stb[5]),
        .watchdog_reload_value(rel), .watchdog_prescale_select(1'b0),
        .reset_pin_drive_enable_set(stb[4]), .reset_indicator_out_n(ind_n),
        .reset_pin_pulldown(pd), .io_tristate(tri_o),
        .config_port_pullup(pu), .bus_abort(abort), .strobes_inactive(strb),
        .cpu_run(run), .restart_addr(addr), .restart_seg(seg),
        .system_config_reg(syscfg), .reset_source(src),
        .watchdog_enabled(wen), .watchdog_count(wcnt),
        .reset_pin_drive_enable(pden));
    always #2 clk = ~clk;
    always @(posedge clk) begin
        if (pd_clr)
            pd_seen <= 1'b0;
        else if (pd === 1'b1)
            pd_seen <= 1'b1;
    end
    ////////////////////////////////////////////////////////////////////////
    task chk(input string nm, input logic [31:0] got, exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task results;
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // bit map of stb: sw reset, end_of_init_instr, service, disable, drive enable, wcw
    task pulse(input [5:0] m);
        @(posedge clk);
        stb <= m;
        @(posedge clk);
        stb <= 6'h00;
        #1;
    endtask
    task wait_run(output int c);
        c = 0;
        while (run !== 1'b1 && c < 2000) begin
            @(posedge clk);
            #1;
            c++;
        end
        chk("run", run, 1'b1);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (10) @(posedge clk);
        reset <= 1'b0;
        repeat (5) @(posedge clk);
        #1;
        chk("pullup", {ind_n, tri_o, pu, wen}, 4'h7);
        @(posedge clk);
        por <= 1'b0;
        wait_run(n);
        chk("src", src, 3'h1);
        chk("cfg", syscfg, 16'hA5C3);
        chk("start", {seg, addr}, 32'h0);
        chk("ind", ind_n, 1'b0);
        pulse(6'h08);
        chk("wen", wen, 1'b0);
        pulse(6'h02);
        chk("ind", ind_n, 1'b1);
        $display("test power_on done");
        for (int b = 0; b < 2; b++) begin
            @(posedge clk);
            bypass <= b[0];
            warm <= 1'b1;
            if (b == 0) pulse(6'h10);
            pd_clr <= 1'b1;
            @(posedge clk);
            pd_clr <= 1'b0;
            req <= 1'b1;
            repeat (8) @(posedge clk);
            req <= 1'b0;
            wait_run(nb[b]);
            chk("src", src, 3'h3);
            chk("pd", pd_seen, b == 0);
            chk("pden", {pden, wen}, 2'h1);
        end
        // pulldown holds the pin to sequence end: two sync stages plus 4 vs 3
        chk("latch", nb[0] - nb[1], 32'h3);
        chk("seq", nb[1] > SEQ, 1'b1);
        $display("test short_reset done");
        @(posedge clk);
        req <= 1'b1;
        repeat (540) @(posedge clk);
        req <= 1'b0;
        wait_run(n);
        chk("src", src, 3'h2);
        $display("test long_reset done");
        @(posedge clk);
        cfg <= 16'h5A3C;
        pulse(6'h01);
        wait_run(n);
        chk("src", src, 3'h5);
        chk("cfg", syscfg, 16'hBA03);
        $display("test soft_reset done");
        pulse(6'h02);
        pulse(6'h08);
        chk("wen", wen, 1'b1);
        @(posedge clk);
        rel <= 8'hFF;
        pulse(6'h20);
        pulse(6'h04);
        chk("cnt", wcnt[15:8], 8'hFF);
        n = 0;
        while (run === 1'b1 && n < 1000) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk("ovf", n >= 505 && n <= 520, 1'b1);
        chk("ind", ind_n, 1'b0);
        wait_run(n);
        chk("src", src, 3'h4);
        $display("test watchdog done");
        // clock gated off: only the asynchronous path can react here
        @(posedge clk);
        {warm, clk_en, req} <= 3'h1;
        @(posedge clk);
        #1;
        chk("async", {ind_n, tri_o, abort, strb}, 4'h7);
        @(posedge clk);
        {clk_en, req} <= 2'h2;
        wait_run(n);
        chk("src", src, 3'h1);
        $display("test async_reset done");
        results;
    end
    // the tests take about 1250 cycles; this allows twenty times that
    initial begin
        #100000;
        err_count++;
        results;
    end
endmodule
